/* sokp_otp_ctrl.sv */
/*
  Holds the key page control block: APB registers, the page control
  register, the completion interrupt and the array sequencer.
  Assumes the engine on, go and mode bits come from same-clock logic and
  the key storage array answers each request with a one-cycle ack.
*/
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "sokp_params.svh"

// Notes on behaviour
// - Bit 7 mirrors configuration page fuse 30.
// - Enabled bit 6 raises interrupt on completion; IRQ_OUT also needs IEN bit 0.
// - Read start bit 5 runs until completion.
// - Page field bits 4-1; above 0111 reserved.
// - Program start bit 0 writes text register.
// - Reset or mode bit clears control fields.
// - Program start also cleared when go clears.
// - Hardware clears start bit at completion.
// - Bits 15-8 read zero, ignore writes.
module sokp_otp_ctrl
  import sokp_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [63:0] CFG_PAGE_IN,
  output logic ARR_REQ_OUT,
  output logic ARR_WRITE_OUT,
  output logic [3:0] ARR_PAGE_OUT,
  output logic [63:0] ARR_WDATA_OUT,
  input wire logic ARR_ACK_IN,
  input wire logic [63:0] ARR_RDATA_IN,
  output logic ENGINE_BUSY_FLAG_OUT,
  output logic IRQ_OUT
);

  logic [15:0] ctrl_reg, ctrl_next;
  logic [2:0] engine_reg, engine_next;
  logic [63:0] text_reg, text_next;
  logic [1:0] stat_reg, stat_next;
  logic [1:0] ien_reg, ien_next;
  logic [31:0] prdata_reg, prdata_next;
  logic wr_en, rd_en, done_pulse, mode_clr, go_clr, bad_page, start;
  logic engine_on_bit, engine_go_flag, engine_mode_bit;
  sokp_req_t seq_req;
  sokp_rsp_t seq_rsp;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // APB decode; every access completes in its first access cycle.

  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd_en = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && (PADDR_IN > `SOKP_OFF_ENGINE);
  assign PRDATA_OUT = prdata_reg;

  assign engine_on_bit = engine_reg[`SOKP_BIT_ENG_ON];
  assign engine_go_flag = engine_reg[`SOKP_BIT_ENG_GO];
  assign engine_mode_bit = engine_reg[`SOKP_BIT_ENG_MODE];
  assign done_pulse = seq_rsp.done;
  assign mode_clr = engine_mode_bit;
  assign go_clr = engine_go_flag && !engine_next[`SOKP_BIT_ENG_GO];
  assign bad_page = ctrl_reg[4:1] > `SOKP_PAGE_MAX;

  //////////////////////////////////////////////////////////////////////////
  // Engine bits and text register.

  always_comb
  begin
    engine_next = engine_reg;
    text_next = text_reg;
    if (wr_en && hit(PADDR_IN, `SOKP_OFF_ENGINE))
      engine_next = PWDATA_IN[2:0];
    if (wr_en && hit(PADDR_IN, `SOKP_OFF_TEXT_LO))
      text_next[31:0] = PWDATA_IN;
    if (wr_en && hit(PADDR_IN, `SOKP_OFF_TEXT_HI))
      text_next[63:32] = PWDATA_IN;
  end

  //////////////////////////////////////////////////////////////////////////
  // Page control register.

  always_comb
  begin
    ctrl_next = ctrl_reg;
    ctrl_next[`SOKP_BIT_PROGRAM_TEST_MIRROR] = CFG_PAGE_IN[`SOKP_TEST_FUSE_BIT];
    if (wr_en && hit(PADDR_IN, `SOKP_OFF_CTRL))
    begin
      ctrl_next[6:1] = PWDATA_IN[6:1];
      if (PWDATA_IN[`SOKP_BIT_READ])
        ctrl_next[`SOKP_BIT_READ] = 1'b1;
      if (PWDATA_IN[`SOKP_BIT_PROG])
        ctrl_next[`SOKP_BIT_PROG] = 1'b1;
      if (ctrl_reg[`SOKP_BIT_READ])
        ctrl_next[`SOKP_BIT_READ] = 1'b1;
    end
    if (done_pulse || (start && bad_page))
    begin
      ctrl_next[`SOKP_BIT_READ] = 1'b0;
      ctrl_next[`SOKP_BIT_PROG] = 1'b0;
    end
    if (go_clr)
      ctrl_next[`SOKP_BIT_PROG] = 1'b0;
    if (mode_clr)
      ctrl_next[6:0] = 7'h00;
    ctrl_next[15:8] = 8'h00;
  end

  assign start = (ctrl_reg[`SOKP_BIT_READ] || ctrl_reg[`SOKP_BIT_PROG])
    && engine_go_flag && !seq_rsp.busy;

  assign seq_req.req = start && !bad_page;
  assign seq_req.write = ctrl_reg[`SOKP_BIT_PROG];
  assign seq_req.page = ctrl_reg[4:1];
  assign seq_req.data = text_reg;

  //////////////////////////////////////////////////////////////////////////
  // Sticky status, enable, and clear register.

  always_comb
  begin
    stat_next = stat_reg;
    ien_next = ien_reg;
    if (wr_en && hit(PADDR_IN, `SOKP_OFF_CLR))
      stat_next = stat_reg & ~PWDATA_IN[1:0];
    if (wr_en && hit(PADDR_IN, `SOKP_OFF_IEN))
      ien_next = PWDATA_IN[1:0];
    if (done_pulse && ctrl_reg[`SOKP_BIT_IE])
      stat_next[`SOKP_ST_DONE] = 1'b1;
    if (start && bad_page)
      stat_next[`SOKP_ST_BADPAGE] = 1'b1;
  end

  assign IRQ_OUT = |(stat_reg & ien_reg);
  assign ENGINE_BUSY_FLAG_OUT = seq_rsp.busy;

  //////////////////////////////////////////////////////////////////////////
  // Read data mux.

  always_comb
  begin
    prdata_next = prdata_reg;
    if (rd_en)
    begin
      prdata_next = 32'h00000000;
      if (hit(PADDR_IN, `SOKP_OFF_CTRL))
        prdata_next = {16'h0000, ctrl_reg};
      else if (hit(PADDR_IN, `SOKP_OFF_STAT))
        prdata_next = {30'h00000000, stat_reg};
      else if (hit(PADDR_IN, `SOKP_OFF_IEN))
        prdata_next = {30'h00000000, ien_reg};
      else if (hit(PADDR_IN, `SOKP_OFF_TEXT_LO))
        prdata_next = text_reg[31:0];
      else if (hit(PADDR_IN, `SOKP_OFF_TEXT_HI))
        prdata_next = text_reg[63:32];
      else if (hit(PADDR_IN, `SOKP_OFF_RDATA_LO))
        prdata_next = seq_rsp.data[31:0];
      else if (hit(PADDR_IN, `SOKP_OFF_RDATA_HI))
        prdata_next = seq_rsp.data[63:32];
      else if (hit(PADDR_IN, `SOKP_OFF_ENGINE))
        prdata_next = {28'h0000000, seq_rsp.busy, engine_reg};
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ctrl_reg <= `SOKP_CTRL_RESET;
      engine_reg <= 3'h0;
      text_reg <= 64'h0000000000000000;
      stat_reg <= 2'h0;
      ien_reg <= 2'h0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      engine_reg <= engine_next;
      text_reg <= text_next;
      stat_reg <= stat_next;
      ien_reg <= ien_next;
      prdata_reg <= prdata_next;
    end
  end

  // Read data is captured at the end of the setup cycle, so PRDATA_OUT
  // stands through the access cycle in which the master takes it.

  sokp_array_seq u_seq (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .abort_in(mode_clr),
    .req_in(seq_req),
    .rsp_out(seq_rsp),
    .arr_req_out(ARR_REQ_OUT),
    .arr_write_out(ARR_WRITE_OUT),
    .arr_page_out(ARR_PAGE_OUT),
    .arr_wdata_out(ARR_WDATA_OUT),
    .arr_ack_in(ARR_ACK_IN),
    .arr_rdata_in(ARR_RDATA_IN)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_MIRROR: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !engine_mode_bit |=> ctrl_reg[7] == $past(CFG_PAGE_IN[30]))
    else $error("Test mirror does not follow fuse.");
  AST_IRQ: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    done_pulse && ctrl_reg[6] && ien_reg[0] |=> IRQ_OUT)
    else $error("Completion interrupt missing.");
  AST_READ_CLR: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    done_pulse |=> !ctrl_reg[5] && !ctrl_reg[0])
    else $error("Start bit not cleared on completion.");
  AST_PAGE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ARR_REQ_OUT |-> ARR_PAGE_OUT <= 4'h7)
    else $error("Reserved page reached the array.");
  AST_PROG_DATA: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    seq_req.req && ctrl_reg[0] |=> ARR_WRITE_OUT
      && ARR_WDATA_OUT == $past(text_reg))
    else $error("Program data differs from text register.");
  AST_MODE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    engine_mode_bit |=> ctrl_reg[6:0] == 7'h00)
    else $error("Mode bit did not clear control.");
  AST_GO: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $fell(engine_go_flag) |-> !ctrl_reg[0])
    else $error("Program start survived go clear.");
  AST_UPPER: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ctrl_reg[15:8] == 8'h00)
    else $error("Upper control bits nonzero.");
  AST_SAME: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $fell(ctrl_reg[5]) && !$past(engine_mode_bit) && $past(ctrl_reg[6])
      && !$past(bad_page) |-> stat_reg[0])
    else $error("Interrupt and start clear not aligned.");
  AST_SPAN: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ARR_REQ_OUT && ARR_ACK_IN && !mode_clr |=> ENGINE_BUSY_FLAG_OUT ##1
      !ENGINE_BUSY_FLAG_OUT)
    else $error("Busy did not end after ack.");

  COV_READ: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    seq_req.req && !seq_req.write ##[1:20] done_pulse);
  COV_PROG: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    seq_req.req && seq_req.write ##[1:20] done_pulse);
  COV_IRQ: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $rose(IRQ_OUT));
  COV_BAD: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    start && bad_page);

endmodule // sokp_otp_ctrl

/* sokp_params.svh */
/*
  Holds the register offsets, field positions and reset values of the
  key page control block.
  Assumes a 32-bit APB bus with one aligned word for each register.
*/
`ifndef SOKP_PARAMS_SVH
`define SOKP_PARAMS_SVH

`define SOKP_OFF_CTRL 12'h000
`define SOKP_OFF_STAT 12'h004
`define SOKP_OFF_CLR 12'h008
`define SOKP_OFF_IEN 12'h00C
`define SOKP_OFF_TEXT_LO 12'h010
`define SOKP_OFF_TEXT_HI 12'h014
`define SOKP_OFF_RDATA_LO 12'h018
`define SOKP_OFF_RDATA_HI 12'h01C
`define SOKP_OFF_ENGINE 12'h020

`define SOKP_BIT_PROG 0
`define SOKP_BIT_PAGE_LO 1
`define SOKP_BIT_READ 5
`define SOKP_BIT_IE 6
`define SOKP_BIT_PROGRAM_TEST_MIRROR 7
`define SOKP_TEST_FUSE_BIT 30

`define SOKP_BIT_ENG_ON 0
`define SOKP_BIT_ENG_GO 1
`define SOKP_BIT_ENG_MODE 2
`define SOKP_BIT_ENG_BUSY 3

`define SOKP_PAGE_MAX 4'h7
`define SOKP_CTRL_RESET 16'h0000
`define SOKP_ST_DONE 0
`define SOKP_ST_BADPAGE 1

`endif

/* sokp_pkg.sv */
/*
  Holds the types shared by the key page control block.
  Assumes the constants header is included by the files that need it.
*/
package sokp_pkg;

  typedef enum logic [1:0] {
    SOKP_IDLE = 2'b00,
    SOKP_RUN = 2'b01,
    SOKP_DONE = 2'b10
  } sokp_state_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [3:0] page;
    logic [63:0] data;
  } sokp_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [63:0] data;
  } sokp_rsp_t;

endpackage

/* sokp_array_seq.sv */
/*
  Holds the sequencer that runs one read or program of the key storage
  array and reports completion.
  Assumes the array answers with a one-cycle ack and holds read data then.
*/
`timescale 1ns/1ps
`include "sokp_params.svh"

module sokp_array_seq
  import sokp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic abort_in,
  input wire sokp_req_t req_in,
  output sokp_rsp_t rsp_out,
  output logic arr_req_out,
  output logic arr_write_out,
  output logic [3:0] arr_page_out,
  output logic [63:0] arr_wdata_out,
  input wire logic arr_ack_in,
  input wire logic [63:0] arr_rdata_in
);

  sokp_state_t state_reg, state_next;
  logic [63:0] data_reg, data_next;
  logic write_reg, write_next;
  logic [3:0] page_reg, page_next;
  logic [63:0] wdata_reg, wdata_next;

  //////////////////////////////////////////////////////////////////////////
  // One operation at a time; an abort drops it without a completion.

  always_comb
  begin
    state_next = state_reg;
    data_next = data_reg;
    write_next = write_reg;
    page_next = page_reg;
    wdata_next = wdata_reg;
    unique case (state_reg)
      SOKP_IDLE:
      begin
        if (req_in.req && !abort_in)
        begin
          state_next = SOKP_RUN;
          write_next = req_in.write;
          page_next = req_in.page;
          wdata_next = req_in.data;
        end
      end
      SOKP_RUN:
      begin
        if (abort_in)
          state_next = SOKP_IDLE;
        else if (arr_ack_in)
        begin
          state_next = SOKP_DONE;
          if (!write_reg)
            data_next = arr_rdata_in;
        end
      end
      SOKP_DONE:
      begin
        state_next = SOKP_IDLE;
      end
      default:
      begin
        state_next = SOKP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= SOKP_IDLE;
      data_reg <= 64'h0000000000000000;
      write_reg <= 1'b0;
      page_reg <= 4'h0;
      wdata_reg <= 64'h0000000000000000;
    end
    else
    begin
      state_reg <= state_next;
      data_reg <= data_next;
      write_reg <= write_next;
      page_reg <= page_next;
      wdata_reg <= wdata_next;
    end
  end

  assign arr_req_out = (state_reg == SOKP_RUN);
  assign arr_write_out = write_reg;
  assign arr_page_out = page_reg;
  assign arr_wdata_out = wdata_reg;
  assign rsp_out.busy = (state_reg != SOKP_IDLE);
  assign rsp_out.done = (state_reg == SOKP_DONE);
  assign rsp_out.data = data_reg;

endmodule // sokp_array_seq

/* sokp_array_model.sv */
/*
  Behavioural key storage array that answers the page sequencer.
  Assumes one request at a time, held until the ack pulse is seen.
*/
`timescale 1ns/1ps

module sokp_array_model
  import sokp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [3:0] page_in,
  input wire logic [63:0] wdata_in,
  input wire logic [3:0] dly_in,
  output logic ack_out,
  output logic [63:0] rdata_out,
  output logic [63:0] cfg_out
);
  logic [63:0] mem [0:7];
  logic [3:0] cnt;
  logic done;

  initial
  begin
    foreach (mem[i])
      mem[i] = 64'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Answers after a chosen delay; read data is only valid with the ack.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt <= 4'h0;
      done <= 1'b0;
      ack_out <= 1'b0;
      rdata_out <= 64'h0;
    end
    else
    begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      cnt <= 4'h0;
      if (req_in && !done && cnt >= dly_in)
      begin
        ack_out <= 1'b1;
        done <= 1'b1;
        if (write_in)
          mem[page_in[2:0]] <= mem[page_in[2:0]] | wdata_in;
        else
          rdata_out <= mem[page_in[2:0]];
      end
      else if (req_in && !done)
        cnt <= cnt + 4'h1;
      else if (!req_in)
        done <= 1'b0;
    end
  end

  assign cfg_out = mem[0];
endmodule // sokp_array_model

/* secure_otp_key_page_control_tb.sv */
/*
  Self-checking bench of the key page control block.
  Assumes the array model answers every request that it sees.
*/
`timescale 1ns/1ps

module secure_otp_key_page_control_tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, serr;
  logic arr_req, arr_write, arr_ack, busy, irq;
  logic req_d = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] arr_page, dly;
  logic [63:0] arr_wdata, arr_rdata, cfg;
  logic [63:0] mem_exp [0:7] = '{default: 64'h0};
  int seed = 35;
  int err_total = 0;
  int cmp_count = 0;
  int req_cnt = 0;

  sokp_otp_ctrl u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .CFG_PAGE_IN(cfg), .ARR_REQ_OUT(arr_req),
    .ARR_WRITE_OUT(arr_write), .ARR_PAGE_OUT(arr_page),
    .ARR_WDATA_OUT(arr_wdata), .ARR_ACK_IN(arr_ack),
    .ARR_RDATA_IN(arr_rdata), .ENGINE_BUSY_FLAG_OUT(busy), .IRQ_OUT(irq));

  sokp_array_model u_arr (.clk_in(clk), .rst_n_in(rst_n), .req_in(arr_req),
    .write_in(arr_write), .page_in(arr_page), .wdata_in(arr_wdata),
    .dly_in(dly), .ack_out(arr_ack), .rdata_out(arr_rdata), .cfg_out(cfg));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    req_d <= arr_req;
    if (arr_req && !req_d)
      req_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic op(input logic wr, input logic [3:0] pg);
    logic [63:0] d;
    logic ie;
    logic [1:0] en;
    logic [15:0] c;
    int n;
    int r0;
    d = {$random(seed), $random(seed)};
    ie = $random(seed);
    en = $random(seed);
    dly <= $random(seed);
    r0 = req_cnt;
    n = 0;
    if (pg == 4'h0)
      d[30] = 1'b1;
    c = {9'h000, ie, ~wr, pg, wr};
    apb(1'b1, 12'h008, 32'h3, q);
    apb(1'b1, 12'h00C, {30'h0, en}, q);
    if (wr)
    begin
      apb(1'b1, 12'h010, d[31:0], q);
      apb(1'b1, 12'h014, d[63:32], q);
      if (pg < 4'h8)
        mem_exp[pg[2:0]] |= d;
    end
    apb(1'b1, 12'h000, {16'h0, c}, q);
    apb(1'b1, 12'h020, 32'h3, q);
    q = 32'h21;
    while ((q & 32'h21) !== 32'h0 && n < 40)
    begin
      apb(1'b0, 12'h000, 32'h0, q);
      n++;
    end
    chk(q, {mem_exp[0][30], ie, 1'b0, pg, 1'b0});
    chk(64'(req_cnt - r0), 64'(pg < 4'h8));
    apb(1'b0, 12'h004, 32'h0, q);
    chk(q, {pg > 4'h7, ie && pg < 4'h8});
    chk(irq, (en[1] && pg > 4'h7) || (en[0] && ie && pg < 4'h8));
    if (!wr && pg < 4'h8)
    begin
      apb(1'b0, 12'h018, 32'h0, q);
      chk(q, mem_exp[pg[2:0]][31:0]);
      apb(1'b0, 12'h01C, 32'h0, q);
      chk(q, mem_exp[pg[2:0]][63:32]);
    end
    apb(1'b1, 12'h008, 32'h3, q);
    chk(irq, 1'b0);
    apb(1'b1, 12'h020, 32'h1, q);
  endtask

  task automatic summarize;
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dly = 4'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b1, 12'h020, 32'h1, q);
    for (int i = 7; i >= 0; i--)
      op(1'b1, i[3:0]);
    for (int i = 0; i < 8; i++)
      op(1'b0, i[3:0]);
    for (int i = 8; i < 16; i++)
      op(i[0], i[3:0]);
    apb(1'b1, 12'h000, 32'hFFCA, q);
    apb(1'b0, 12'h000, 32'h0, q);
    chk(q, {mem_exp[0][30], 7'h4A});
    dly <= 4'hF;
    apb(1'b1, 12'h010, 32'h0, q);
    apb(1'b1, 12'h014, 32'h0, q);
    apb(1'b1, 12'h000, 32'h3, q);
    apb(1'b0, 12'h000, 32'h0, q);
    chk(q[0], 1'b1);
    apb(1'b1, 12'h020, 32'h3, q);
    apb(1'b1, 12'h020, 32'h1, q);
    apb(1'b0, 12'h000, 32'h0, q);
    chk(q[0], 1'b0);
    chk(busy, 1'b1);
    while (busy === 1'b1)
      @(posedge clk);
    apb(1'b1, 12'h000, 32'h4A, q);
    apb(1'b1, 12'h020, 32'h4, q);
    apb(1'b0, 12'h000, 32'h0, q);
    chk(q, {mem_exp[0][30], 7'h00});
    apb(1'b0, 12'h024, 32'h0, q);
    chk(serr, 1'b1);
    summarize;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize;
  end
endmodule // secure_otp_key_page_control_tb
